// ==== shared/alu_pkg.sv ====
// Purpose: shared types and constants of the arithmetic, logic and multiply datapath
// Assumes: one core clock, 8-bit working registers, 16-bit register pairs
// Notes: flag bit positions and register offsets are local to this block
package alu_pkg;

  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int FLAG_W = 6;
  localparam int ADDR_W = 4;

  // condition flag positions inside the flag register
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  // which flags each group of operations updates
  localparam logic [FLAG_W-1:0] FM_ARITH = 6'h2F;
  localparam logic [FLAG_W-1:0] FM_WORD = 6'h1F;
  localparam logic [FLAG_W-1:0] FM_LOGIC = 6'h0E;
  localparam logic [FLAG_W-1:0] FM_ONES = 6'h0F;
  localparam logic [FLAG_W-1:0] FM_PROD = 6'h03;
  localparam logic [FLAG_W-1:0] FM_NONE = 6'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;

  localparam logic [DATA_W-1:0] ZERO8 = 8'h00;
  localparam logic [DATA_W-1:0] ONE8 = 8'h01;
  localparam logic [DATA_W-1:0] ALL_ONES = 8'hFF;
  localparam logic [WORD_W-1:0] ZERO16 = 16'h0000;

  // register port offsets
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RES_LO = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_RES_HI = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;

  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_ADD_CARRY, OP_WORD_ADD_IMMEDIATE, OP_SUBTRACT,
    OP_SUBTRACT_IMMEDIATE, OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_IMMEDIATE_WITH_BORROW,
    OP_WORD_SUBTRACT_IMMEDIATE, OP_CONJUNCTION, OP_CONJUNCTION_IMMEDIATE,
    OP_DISJUNCTION, OP_DISJUNCTION_IMMEDIATE, OP_EXCLUSIVE_DISJUNCTION,
    OP_ONES_COMPLEMENT_OP, OP_TWOS_COMPLEMENT_OP, OP_SET_BITS_OP, OP_CLEAR_BITS_OP,
    OP_INCREMENT, OP_DECREMENT, OP_ZERO_MINUS_TEST, OP_REGISTER_CLEAR_OP,
    OP_REGISTER_ALL_ONES_OP, OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT,
    OP_MIXED_SIGN_PRODUCT, OP_FRACTIONAL_UNSIGNED_PRODUCT,
    OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT
  } alu_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_SECOND = 2'h2
  } seq_state_type;

  typedef struct packed {
    alu_op_type op;
    logic [DATA_W-1:0] dst;
    logic [DATA_W-1:0] dst_hi;
    logic [DATA_W-1:0] src;
    logic [DATA_W-1:0] imm;
  } alu_request_type;

  typedef struct packed {
    logic [WORD_W-1:0] value;
    logic wide;
    logic product_pair;
  } alu_result_type;

  typedef struct packed {
    logic [DATA_W-1:0] r;
    logic c;
    logic h;
    logic v;
  } arith_out_type;

  typedef struct packed {
    seq_state_type st;
    alu_op_type op;
    logic [WORD_W-1:0] word;
    logic [DATA_W-1:0] imm;
    alu_result_type res;
    logic res_valid;
    logic busy;
    logic [FLAG_W-1:0] flags;
    logic [DATA_W-1:0] rdata;
  } alu_state_type;

  localparam alu_state_type ALU_STATE_RESET = '{
    st: ST_IDLE, op: OP_NONE, word: ZERO16, imm: ZERO8,
    res: '{value: ZERO16, wide: 1'b0, product_pair: 1'b0},
    res_valid: 1'b0, busy: 1'b0, flags: FLAGS_RESET, rdata: ZERO8};

  typedef struct packed {
    logic [WORD_W-1:0] product;
    logic carry;
    logic zero;
  } product_state_type;

  localparam product_state_type PRODUCT_RESET = '{product: ZERO16, carry: 1'b0, zero: 1'b0};

endpackage

// ==== core/alu_product_unit.sv ====
// Purpose: registered 8x8 multiplier for integer and fractional products
// Assumes: operands presented in the cycle the request is taken
// Notes: captures every cycle; the caller reads it one cycle after taking
`timescale 1ns/100ps
`default_nettype none
module alu_product_unit
  import alu_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // operands and mode
  input wire logic [DATA_W-1:0] lhs_i,
  input wire logic [DATA_W-1:0] rhs_i,
  input wire logic lhs_signed_i,
  input wire logic rhs_signed_i,
  input wire logic fractional_i,
  // registered product and flags
  output logic [WORD_W-1:0] product_o,
  output logic carry_o,
  output logic zero_o
);

  product_state_type cur, nxt;
  logic signed [DATA_W:0] lhs_ext;
  logic signed [DATA_W:0] rhs_ext;
  logic signed [2*DATA_W+1:0] full;
  logic [WORD_W-1:0] raw;

  always_comb begin
    // a ninth bit turns unsigned operands into non-negative signed ones
    lhs_ext = signed'({lhs_signed_i & lhs_i[DATA_W-1], lhs_i});
    rhs_ext = signed'({rhs_signed_i & rhs_i[DATA_W-1], rhs_i});
    full = lhs_ext * rhs_ext;
    raw = full[WORD_W-1:0];
    nxt = cur;
    nxt.product = fractional_i ? {raw[WORD_W-2:0], 1'b0} : raw;
    nxt.carry = raw[WORD_W-1];
    nxt.zero = (nxt.product == ZERO16);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur <= PRODUCT_RESET;
    end else begin
      cur <= nxt;
    end
  end

  assign product_o = cur.product;
  assign carry_o = cur.carry;
  assign zero_o = cur.zero;

endmodule
`default_nettype wire

// ==== core/alu_arith_logic_multiply.sv ====
// Purpose: arithmetic, logic and multiply execution datapath of an 8-bit core
// Assumes: decoder drives a request with START_I for one cycle, same clock
// Notes: one-clock ops answer next cycle, two-clock ops two cycles later
//
// Overview of operation
// - add and add-with-carry, five flags, one clock
// - word add immediate on pair, two clocks
// - subtract register or immediate, one clock
// - subtract with borrow between registers, one clock
// - subtract immediate with borrow, one clock
// - word subtract immediate on pair, two clocks
// - conjunction register or immediate, Z N V
// - disjunctions and exclusive disjunction, Z N V
// - set bits is disjunction with mask
// - clear bits ands with inverted mask
// - test ands register with itself, flags
// - integer products into product pair, Z C
// - fractional products shifted left one bit
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module alu_arith_logic_multiply
  import alu_pkg::*;
(
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // request from the decoder
  input wire logic START_I,
  input wire alu_request_type REQ_I,
  // result to the register file
  output logic RES_VALID_O,
  output alu_result_type RES_O,
  output logic BUSY_O,
  output logic [FLAG_W-1:0] FLAGS_O,
  // register port
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic [DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [DATA_W-1:0] REG_RDATA_O
);

  alu_state_type cur, nxt;
  arith_out_type ao;
  logic [FLAG_W-1:0] fmask;
  logic [FLAG_W-1:0] fcalc;
  logic [WORD_W:0] wsum;
  logic [WORD_W-1:0] wres;
  logic legal;
  logic carry_in;
  logic prod_lhs_signed;
  logic prod_rhs_signed;
  logic prod_fractional;
  logic [WORD_W-1:0] prod_value;
  logic prod_carry;
  logic prod_zero;

  function automatic arith_out_type add8(input logic [DATA_W-1:0] a,
                                         input logic [DATA_W-1:0] b, input logic cin);
    arith_out_type o;
    logic [DATA_W:0] s;
    logic [4:0] ls;
    s = {1'b0, a} + {1'b0, b} + {ZERO8, cin};
    ls = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    o.r = s[DATA_W-1:0];
    o.c = s[DATA_W];
    o.h = ls[4];
    o.v = (a[DATA_W-1] == b[DATA_W-1]) && (o.r[DATA_W-1] != a[DATA_W-1]);
    return o;
  endfunction

  // borrow out of bit 7 and bit 3 lands in c and h
  function automatic arith_out_type sub8(input logic [DATA_W-1:0] a,
                                         input logic [DATA_W-1:0] b, input logic bin);
    arith_out_type o;
    logic [DATA_W:0] s;
    logic [4:0] ls;
    s = {1'b0, a} - {1'b0, b} - {ZERO8, bin};
    ls = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
    o.r = s[DATA_W-1:0];
    o.c = s[DATA_W];
    o.h = ls[4];
    o.v = (a[DATA_W-1] != b[DATA_W-1]) && (o.r[DATA_W-1] != a[DATA_W-1]);
    return o;
  endfunction

  function automatic logic is_two_clock(input alu_op_type op);
    return op inside {OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE,
                      OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
                      OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
                      OP_FRACTIONAL_MIXED_PRODUCT};
  endfunction

  assign carry_in = cur.flags[FLAG_C];
  assign prod_lhs_signed = REQ_I.op inside {OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
                                            OP_FRACTIONAL_SIGNED_PRODUCT,
                                            OP_FRACTIONAL_MIXED_PRODUCT};
  assign prod_rhs_signed = REQ_I.op inside {OP_SIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT};
  assign prod_fractional = REQ_I.op inside {OP_FRACTIONAL_UNSIGNED_PRODUCT,
                                            OP_FRACTIONAL_SIGNED_PRODUCT,
                                            OP_FRACTIONAL_MIXED_PRODUCT};

  // the multiplier captures every cycle; only the taken request's product is used
  alu_product_unit u_product (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .lhs_i(REQ_I.dst),
    .rhs_i(REQ_I.src),
    .lhs_signed_i(prod_lhs_signed),
    .rhs_signed_i(prod_rhs_signed),
    .fractional_i(prod_fractional),
    .product_o(prod_value),
    .carry_o(prod_carry),
    .zero_o(prod_zero)
  );

  always_comb begin
    nxt = cur;
    nxt.res_valid = 1'b0;
    ao = '{r: REQ_I.dst, c: 1'b0, h: 1'b0, v: 1'b0};
    fmask = FM_NONE;
    fcalc = FLAGS_RESET;
    wsum = '0;
    wres = ZERO16;
    legal = 1'b1;
    if (REG_WR_I && (REG_ADDR_I == ADDR_FLAGS)) begin
      nxt.flags = REG_WDATA_I[FLAG_W-1:0];
    end
    nxt.rdata = ZERO8;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        ADDR_FLAGS: nxt.rdata = {2'h0, cur.flags};
        ADDR_RES_LO: nxt.rdata = cur.res.value[DATA_W-1:0];
        ADDR_RES_HI: nxt.rdata = cur.res.value[WORD_W-1:DATA_W];
        ADDR_STATUS: nxt.rdata = {7'h00, cur.busy};
        default: nxt.rdata = ZERO8;
      endcase
    end
    unique case (cur.st)
      ST_IDLE: begin
        if (START_I && is_two_clock(REQ_I.op)) begin
          nxt.st = ST_SECOND;
          nxt.busy = 1'b1;
          nxt.op = REQ_I.op;
          nxt.word = {REQ_I.dst_hi, REQ_I.dst};
          nxt.imm = REQ_I.imm;
        end else if (START_I) begin
          case (REQ_I.op)
            OP_ADD: begin
              ao = add8(REQ_I.dst, REQ_I.src, 1'b0);
              fmask = FM_ARITH;
            end
            OP_ADD_CARRY: begin
              ao = add8(REQ_I.dst, REQ_I.src, carry_in);
              fmask = FM_ARITH;
            end
            OP_SUBTRACT: begin
              ao = sub8(REQ_I.dst, REQ_I.src, 1'b0);
              fmask = FM_ARITH;
            end
            OP_SUBTRACT_IMMEDIATE: begin
              ao = sub8(REQ_I.dst, REQ_I.imm, 1'b0);
              fmask = FM_ARITH;
            end
            OP_SUBTRACT_WITH_BORROW: begin
              ao = sub8(REQ_I.dst, REQ_I.src, carry_in);
              fmask = FM_ARITH;
            end
            OP_SUBTRACT_IMMEDIATE_WITH_BORROW: begin
              ao = sub8(REQ_I.dst, REQ_I.imm, carry_in);
              fmask = FM_ARITH;
            end
            OP_CONJUNCTION: begin
              ao.r = REQ_I.dst & REQ_I.src;
              fmask = FM_LOGIC;
            end
            OP_CONJUNCTION_IMMEDIATE: begin
              ao.r = REQ_I.dst & REQ_I.imm;
              fmask = FM_LOGIC;
            end
            OP_DISJUNCTION: begin
              ao.r = REQ_I.dst | REQ_I.src;
              fmask = FM_LOGIC;
            end
            OP_DISJUNCTION_IMMEDIATE, OP_SET_BITS_OP: begin
              ao.r = REQ_I.dst | REQ_I.imm;
              fmask = FM_LOGIC;
            end
            OP_EXCLUSIVE_DISJUNCTION: begin
              ao.r = REQ_I.dst ^ REQ_I.src;
              fmask = FM_LOGIC;
            end
            OP_CLEAR_BITS_OP: begin
              ao.r = REQ_I.dst & (ALL_ONES - REQ_I.imm);
              fmask = FM_LOGIC;
            end
            OP_ZERO_MINUS_TEST: begin
              ao.r = REQ_I.dst & REQ_I.dst;
              fmask = FM_LOGIC;
            end
            OP_ONES_COMPLEMENT_OP: begin
              ao.r = ALL_ONES - REQ_I.dst;
              ao.c = 1'b1;
              fmask = FM_ONES;
            end
            OP_TWOS_COMPLEMENT_OP: begin
              ao = sub8(ZERO8, REQ_I.dst, 1'b0);
              fmask = FM_ARITH;
            end
            OP_INCREMENT: begin
              ao = add8(REQ_I.dst, ONE8, 1'b0);
              fmask = FM_LOGIC;
            end
            OP_DECREMENT: begin
              ao = sub8(REQ_I.dst, ONE8, 1'b0);
              fmask = FM_LOGIC;
            end
            OP_REGISTER_CLEAR_OP: begin
              ao.r = REQ_I.dst ^ REQ_I.dst;
              fmask = FM_LOGIC;
            end
            OP_REGISTER_ALL_ONES_OP: begin
              ao.r = ALL_ONES;
              fmask = FM_NONE;
            end
            default: begin
              legal = 1'b0;
            end
          endcase
          fcalc[FLAG_C] = ao.c;
          fcalc[FLAG_Z] = (ao.r == ZERO8);
          fcalc[FLAG_N] = ao.r[DATA_W-1];
          fcalc[FLAG_V] = ao.v;
          fcalc[FLAG_S] = ao.r[DATA_W-1] ^ ao.v;
          fcalc[FLAG_H] = ao.h;
          // unknown codes are dropped silently, no answer and no flag change
          if (legal) begin
            nxt.res = '{value: {ZERO8, ao.r}, wide: 1'b0, product_pair: 1'b0};
            nxt.res_valid = 1'b1;
          end else begin
            fmask = FM_NONE;
          end
        end
      end
      ST_SECOND: begin
        nxt.st = ST_IDLE;
        nxt.busy = 1'b0;
        nxt.res_valid = 1'b1;
        if (cur.op == OP_WORD_ADD_IMMEDIATE || cur.op == OP_WORD_SUBTRACT_IMMEDIATE) begin
          if (cur.op == OP_WORD_ADD_IMMEDIATE) begin
            wsum = {1'b0, cur.word} + {9'h000, cur.imm};
            wres = wsum[WORD_W-1:0];
            fcalc[FLAG_V] = !cur.word[WORD_W-1] && wres[WORD_W-1];
            fcalc[FLAG_C] = !wres[WORD_W-1] && cur.word[WORD_W-1];
          end else begin
            wsum = {1'b0, cur.word} - {9'h000, cur.imm};
            wres = wsum[WORD_W-1:0];
            fcalc[FLAG_V] = cur.word[WORD_W-1] && !wres[WORD_W-1];
            fcalc[FLAG_C] = wres[WORD_W-1] && !cur.word[WORD_W-1];
          end
          fcalc[FLAG_N] = wres[WORD_W-1];
          fcalc[FLAG_Z] = (wres == ZERO16);
          fcalc[FLAG_S] = fcalc[FLAG_N] ^ fcalc[FLAG_V];
          fmask = FM_WORD;
          nxt.res = '{value: wres, wide: 1'b1, product_pair: 1'b0};
        end else begin
          fcalc[FLAG_C] = prod_carry;
          fcalc[FLAG_Z] = prod_zero;
          fmask = FM_PROD;
          nxt.res = '{value: prod_value, wide: 1'b1, product_pair: 1'b1};
        end
      end
    endcase
    // an op's flag update wins over a software write in the same cycle
    nxt.flags = (nxt.flags & ~fmask) | (fcalc & fmask);
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cur <= ALU_STATE_RESET;
    end else begin
      cur <= nxt;
    end
  end

  assign RES_VALID_O = cur.res_valid;
  assign RES_O = cur.res;
  assign BUSY_O = cur.busy;
  assign FLAGS_O = cur.flags;
  assign REG_RDATA_O = cur.rdata;

  // checking logic
  logic take;
  logic [DATA_W-1:0] pd;
  logic [DATA_W-1:0] ps;
  logic [DATA_W-1:0] pk;
  logic [WORD_W-1:0] pw;
  assign take = START_I && (cur.st == ST_IDLE);
  assign pd = REQ_I.dst;
  assign ps = REQ_I.src;
  assign pk = REQ_I.imm;
  assign pw = {REQ_I.dst_hi, REQ_I.dst};

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_take_word_add;
    take && (REQ_I.op == OP_WORD_ADD_IMMEDIATE);
  endsequence
  sequence s_take_word_sub;
    take && (REQ_I.op == OP_WORD_SUBTRACT_IMMEDIATE);
  endsequence
  sequence s_hold_busy;
    BUSY_O && !RES_VALID_O;
  endsequence

  AST_ADD_SUM: assert property (take && REQ_I.op inside {OP_ADD, OP_ADD_CARRY} |=>
    RES_VALID_O && RES_O.value[DATA_W-1:0] == 8'($past(pd) + $past(ps)
      + ($past(REQ_I.op) == OP_ADD_CARRY ? $past(carry_in) : 1'b0)))
    else $error("add result wrong");
  AST_WORD_ADD: assert property (s_take_word_add |=> s_hold_busy ##1
    (RES_VALID_O && RES_O.wide && RES_O.value == 16'($past(pw, 2) + {ZERO8, $past(pk, 2)})))
    else $error("word add wrong or not two clocks");
  AST_SUB_IMM: assert property (take && REQ_I.op == OP_SUBTRACT_IMMEDIATE |=>
    RES_O.value[DATA_W-1:0] == 8'($past(pd) - $past(pk))
      && FLAGS_O[FLAG_C] == ($past(pk) > $past(pd)))
    else $error("subtract immediate wrong");
  AST_SUB_BORROW: assert property (take && REQ_I.op == OP_SUBTRACT_WITH_BORROW |=>
    RES_VALID_O && RES_O.value[DATA_W-1:0] == 8'($past(pd) - $past(ps) - $past(carry_in)))
    else $error("subtract with borrow wrong");
  AST_SUB_IMM_BORROW: assert property (
    take && REQ_I.op == OP_SUBTRACT_IMMEDIATE_WITH_BORROW |=>
    RES_O.value[DATA_W-1:0] == 8'($past(pd) - $past(pk) - $past(carry_in))
      && FLAGS_O[FLAG_Z] == (RES_O.value[DATA_W-1:0] == ZERO8))
    else $error("subtract immediate with borrow wrong");
  AST_WORD_SUB: assert property (s_take_word_sub |=> s_hold_busy ##1
    (RES_O.value == 16'($past(pw, 2) - {ZERO8, $past(pk, 2)})
      && FLAGS_O[FLAG_S] == (FLAGS_O[FLAG_N] ^ FLAGS_O[FLAG_V])))
    else $error("word subtract wrong");
  AST_CONJ: assert property (take && REQ_I.op == OP_CONJUNCTION |=>
    RES_O.value[DATA_W-1:0] == ($past(pd) & $past(ps)) && !FLAGS_O[FLAG_V])
    else $error("conjunction wrong");
  AST_XOR: assert property (take && REQ_I.op == OP_EXCLUSIVE_DISJUNCTION |=>
    RES_O.value[DATA_W-1:0] == ($past(pd) ^ $past(ps))
      && FLAGS_O[FLAG_N] == RES_O.value[DATA_W-1])
    else $error("exclusive disjunction wrong");
  AST_SET_BITS: assert property (take && REQ_I.op == OP_SET_BITS_OP |=>
    RES_VALID_O && RES_O.value[DATA_W-1:0] == ($past(pd) | $past(pk)))
    else $error("set bits wrong");
  AST_CLEAR_BITS: assert property (take && REQ_I.op == OP_CLEAR_BITS_OP |=>
    RES_O.value[DATA_W-1:0] == ($past(pd) & ~$past(pk)))
    else $error("clear bits wrong");
  AST_TEST: assert property (take && REQ_I.op == OP_ZERO_MINUS_TEST |=>
    RES_O.value[DATA_W-1:0] == $past(pd) && FLAGS_O[FLAG_Z] == ($past(pd) == ZERO8))
    else $error("test flags wrong");
  AST_PRODUCT: assert property (take && REQ_I.op == OP_UNSIGNED_PRODUCT |=>
    !RES_VALID_O ##1 (RES_VALID_O && RES_O.product_pair
      && RES_O.value == ({ZERO8, $past(pd, 2)} * {ZERO8, $past(ps, 2)})))
    else $error("unsigned product wrong");
  AST_FRAC: assert property (take && REQ_I.op == OP_FRACTIONAL_UNSIGNED_PRODUCT |->
    ##2 (RES_O.value == (({ZERO8, $past(pd, 2)} * {ZERO8, $past(ps, 2)}) << 1)
      && FLAGS_O[FLAG_Z] == (RES_O.value == ZERO16)))
    else $error("fractional product wrong");
  AST_ONES: assert property (take && REQ_I.op == OP_ONES_COMPLEMENT_OP |=>
    RES_O.value[DATA_W-1:0] == ~$past(pd) && FLAGS_O[FLAG_C])
    else $error("ones complement wrong");
  AST_ALL_ONES: assert property (
    take && REQ_I.op == OP_REGISTER_ALL_ONES_OP && !REG_WR_I |=>
    RES_O.value[DATA_W-1:0] == ALL_ONES && $stable(FLAGS_O))
    else $error("all ones changed flags");

endmodule
`default_nettype wire

// ==== dv/decoder_model.sv ====
// Purpose: decoder-side model that issues datapath requests and times the answers
// Assumes: tasks are entered just after a rising edge of the core clock
// Notes: latency is counted in edges from the taking edge to the answer
`timescale 1ns/100ps
`default_nettype none
module decoder_model
  import alu_pkg::*;
(
  // clock
  input wire logic clk_i,
  // answer from the datapath
  input wire logic res_valid_i,
  input wire logic busy_i,
  // request to the datapath
  output var logic start_o,
  output var alu_request_type req_o
);
  int n_valid = 0;

  initial begin
    start_o = 1'b0;
    req_o = '0;
  end

  always @(posedge clk_i) begin
    if (res_valid_i === 1'b1) begin
      n_valid++;
    end
  end

  // hold keeps the strobe up one more edge so that it meets a busy datapath
  task automatic issue(input alu_request_type r, input bit hold, output int lat,
      output bit busy_seen);
    start_o <= 1'b1;
    req_o <= r;
    @(posedge clk_i);
    if (!hold) begin
      start_o <= 1'b0;
    end
    lat = 0;
    busy_seen = 1'b0;
    while (lat < 8) begin
      #1;
      lat++;
      if (busy_i === 1'b1) begin
        busy_seen = 1'b1;
      end
      if (res_valid_i === 1'b1) begin
        break;
      end
      @(posedge clk_i);
      start_o <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench of the arithmetic, logic and multiply datapath
// Assumes: flags are preset over the register port before every operation issued by run
// Notes: expected values are worked out by hand from the operation definitions
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import alu_pkg::*;
  logic mclk;
  logic rst_n;
  logic start;
  alu_request_type req;
  logic res_valid;
  alu_result_type res;
  logic busy;
  logic [FLAG_W-1:0] flags;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  int n_errors = 0;
  int samples_checked = 0;

  alu_arith_logic_multiply i_alu_arith_logic_multiply (
    .MCLK_I(mclk), .RST_N_I(rst_n), .START_I(start), .REQ_I(req),
    .RES_VALID_O(res_valid), .RES_O(res), .BUSY_O(busy), .FLAGS_O(flags),
    .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
    .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata));

  decoder_model i_decoder_model (
    .clk_i(mclk), .res_valid_i(res_valid), .busy_i(busy), .start_o(start), .req_o(req));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
    // read data stand for one cycle only and fall back to zero
    @(posedge mclk);
    #1;
    chk({8'h00, reg_rdata}, 16'h0000);
  endtask

  // fin presets every flag so untouched bits can be seen to survive
  task automatic run(input alu_op_type op, input logic [7:0] d, input logic [7:0] h,
      input logic [7:0] s, input logic [7:0] k, input logic [5:0] fin,
      input logic [15:0] ev, input logic [5:0] ef);
    int lat;
    bit bs;
    bit two;
    bit pp;
    pp = op >= OP_UNSIGNED_PRODUCT;
    two = pp || op == OP_WORD_ADD_IMMEDIATE || op == OP_WORD_SUBTRACT_IMMEDIATE;
    wr(ADDR_FLAGS, {2'b00, fin});
    @(posedge mclk);
    i_decoder_model.issue('{op: op, dst: d, dst_hi: h, src: s, imm: k}, 1'b0, lat, bs);
    chk(16'(lat), two ? 16'h0002 : 16'h0001);
    chk({15'h0000, bs}, {15'h0000, two});
    chk(res.value, ev);
    chk({10'h000, flags}, {10'h000, ef});
    chk({14'h0000, res.wide, res.product_pair}, {14'h0000, two, pp});
    if (lat >= 8) begin
      report_and_stop();
    end
  endtask

  initial begin
    int n0;
    int lat;
    bit bs;
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rd(ADDR_FLAGS, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    run(OP_ADD, 8'h7F, 8'h00, 8'h01, 8'h00, 6'h10, 16'h0080, 6'h3C);
    run(OP_ADD_CARRY, 8'hFF, 8'h00, 8'h00, 8'h00, 6'h01, 16'h0000, 6'h23);
    run(OP_WORD_ADD_IMMEDIATE, 8'hFF, 8'hFF, 8'h5A, 8'h01, 6'h20, 16'h0000,
        6'h23);
    run(OP_SUBTRACT, 8'h00, 8'h00, 8'h01, 8'h00, 6'h00, 16'h00FF, 6'h25);
    run(OP_SUBTRACT_IMMEDIATE, 8'h80, 8'h00, 8'h40, 8'h01, 6'h00, 16'h007F,
        6'h28);
    run(OP_SUBTRACT_WITH_BORROW, 8'h10, 8'h00, 8'h0F, 8'h00, 6'h01, 16'h0000,
        6'h22);
    run(OP_SUBTRACT_IMMEDIATE_WITH_BORROW, 8'h00, 8'h00, 8'h33, 8'h00, 6'h01, 16'h00FF,
        6'h25);
    run(OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, 8'h80, 8'h5A, 8'h01, 6'h00, 16'h7FFF,
        6'h18);
    run(OP_CONJUNCTION, 8'hF0, 8'h00, 8'h90, 8'h00, 6'h39, 16'h0090, 6'h35);
    run(OP_CONJUNCTION_IMMEDIATE, 8'h0F, 8'h00, 8'hFF, 8'hF0, 6'h00, 16'h0000,
        6'h02);
    run(OP_DISJUNCTION, 8'h80, 8'h00, 8'h01, 8'h00, 6'h00, 16'h0081, 6'h04);
    run(OP_DISJUNCTION_IMMEDIATE, 8'h00, 8'h00, 8'h77, 8'h00, 6'h08, 16'h0000,
        6'h02);
    run(OP_EXCLUSIVE_DISJUNCTION, 8'hAA, 8'h00, 8'hAA, 8'h00, 6'h04, 16'h0000,
        6'h02);
    run(OP_SET_BITS_OP, 8'h01, 8'h00, 8'h00, 8'h80, 6'h00, 16'h0081, 6'h04);
    run(OP_CLEAR_BITS_OP, 8'hFF, 8'h00, 8'h00, 8'h0F, 6'h01, 16'h00F0, 6'h05);
    run(OP_ZERO_MINUS_TEST, 8'h00, 8'h00, 8'h00, 8'h00, 6'h0C, 16'h0000, 6'h02);
    run(OP_ONES_COMPLEMENT_OP, 8'h55, 8'h00, 8'h00, 8'h00, 6'h20, 16'h00AA,
        6'h25);
    run(OP_TWOS_COMPLEMENT_OP, 8'h80, 8'h00, 8'h00, 8'h00, 6'h00, 16'h0080,
        6'h0D);
    run(OP_INCREMENT, 8'h7F, 8'h00, 8'h00, 8'h00, 6'h01, 16'h0080, 6'h0D);
    run(OP_DECREMENT, 8'h80, 8'h00, 8'h00, 8'h00, 6'h00, 16'h007F, 6'h08);
    run(OP_REGISTER_CLEAR_OP, 8'h5A, 8'h00, 8'h00, 8'h00, 6'h0C, 16'h0000,
        6'h02);
    run(OP_REGISTER_ALL_ONES_OP, 8'h00, 8'h00, 8'h00, 8'h00, 6'h3F, 16'h00FF,
        6'h3F);
    run(OP_UNSIGNED_PRODUCT, 8'hFF, 8'h00, 8'hFF, 8'h00, 6'h3C, 16'hFE01,
        6'h3D);
    run(OP_UNSIGNED_PRODUCT, 8'h00, 8'h00, 8'h37, 8'h00, 6'h01, 16'h0000,
        6'h02);
    run(OP_SIGNED_PRODUCT, 8'h80, 8'h00, 8'h80, 8'h00, 6'h00, 16'h4000, 6'h00);
    run(OP_MIXED_SIGN_PRODUCT, 8'hFF, 8'h00, 8'h02, 8'h00, 6'h00, 16'hFFFE,
        6'h01);
    run(OP_FRACTIONAL_UNSIGNED_PRODUCT, 8'h80, 8'h00, 8'h80, 8'h00, 6'h00, 16'h8000,
        6'h00);
    run(OP_FRACTIONAL_SIGNED_PRODUCT, 8'h80, 8'h00, 8'h80, 8'h00, 6'h00, 16'h8000,
        6'h00);
    run(OP_FRACTIONAL_MIXED_PRODUCT, 8'hC0, 8'h00, 8'h80, 8'h00, 6'h00, 16'hC000,
        6'h01);
    rd(ADDR_RES_HI, 8'hC0);
    wr(ADDR_RES_HI, 8'h12);
    rd(ADDR_RES_HI, 8'hC0);
    rd(4'h7, 8'h00);
    wr(ADDR_FLAGS, 8'hFF);
    rd(ADDR_FLAGS, 8'h3F);
    // a strobe held into the busy cycle must not start a second product
    n0 = i_decoder_model.n_valid;
    @(posedge mclk);
    i_decoder_model.issue('{op: OP_UNSIGNED_PRODUCT, dst: 8'h03, dst_hi: 8'h00, src: 8'h05,
        imm: 8'h00}, 1'b1, lat, bs);
    repeat (4) @(posedge mclk);
    chk(16'(i_decoder_model.n_valid - n0), 16'h0001);
    chk(res.value, 16'h000F);
    // an unused code is taken and dropped: no answer and the flags stay
    @(posedge mclk);
    i_decoder_model.issue('{op: OP_NONE, dst: 8'h00, dst_hi: 8'h00, src: 8'h00, imm: 8'h00},
        1'b0, lat, bs);
    chk(16'(lat), 16'h0008);
    chk(16'(i_decoder_model.n_valid - n0), 16'h0001);
    chk({10'h000, flags}, 16'h003C);
    // carry chains between back-to-back requests
    @(posedge mclk);
    i_decoder_model.issue('{op: OP_ADD, dst: 8'hFF, dst_hi: 8'h00, src: 8'h01, imm: 8'h00},
        1'b0, lat, bs);
    i_decoder_model.issue('{op: OP_ADD_CARRY, dst: 8'h00, dst_hi: 8'h00, src: 8'h00,
        imm: 8'h00}, 1'b0, lat, bs);
    chk(res.value, 16'h0001);
    chk({10'h000, flags}, 16'h0010);
    // a software flag write in the taking edge keeps only the bits the op leaves alone
    fork
      wr(ADDR_FLAGS, 8'h3F);
      begin
        @(posedge mclk);
        i_decoder_model.issue('{op: OP_INCREMENT, dst: 8'h7F, dst_hi: 8'h00, src: 8'h00,
            imm: 8'h00}, 1'b0, lat, bs);
      end
    join
    chk({10'h000, flags}, 16'h003D);
    report_and_stop();
  end

  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
